// [rtl/interrupt_mask_priority.sv]
// interrupt mask, holding register, priority encoder and enable flags
// Functional notes
// - sixteen-bit mask; bit n enables interrupt line n
// - a line whose mask bit is clear is never captured
// - mask-load flag sets at A-cycle 250 on register-execute inter-register with X bit 0
// - mask-load flag also sets with console mask selector and Q-to-adder flag
// - with mask-load flag set, mask loads adder/shifter bits at time 300
// - stored mask is routed back to the adder/shifter
// - holding bit sets at A-cycle 50: mask, line, enable, interrupt-taken clear
// - encoder turns held line into its four-bit binary number
// - with several lines held, the lowest-numbered one wins
// - exit offset equals four times the state number
// - return address at 0100 plus offset; handler starts at 0101 plus offset
// - exit instruction reads stored return word by offset and jumps there
// - state code is passed to the Y register
// - registers are built from four-bit slices, four for sixteen lines
// - first enable at B-cycle 250 on enable/exit; second at B-cycle 200 indirect
// - interrupt-taken sets at A-cycle 250: second enable, pending, indirect or next-read
// - enable and interrupt-taken flags clear at A-cycle 300 on entry and A-cycle 200 on exit op
`default_nettype none
module interrupt_mask_priority (
    // clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    // sequencer cycles and timing points, one-cycle strobes
    input wire logic cycle_a,
    input wire logic cycle_b,
    input wire logic time_050,
    input wire logic time_200,
    input wire logic time_250,
    input wire logic time_300,
    // sequencer phases
    input wire logic reg_phase,
    input wire logic ind_addr_phase,
    input wire logic read_next_instruction_phase,
    // decoded instruction
    input wire logic inter_register_instr,
    input wire logic exit_interrupt_instr,
    input wire logic enable_interrupt_instr,
    input wire logic interrupt_exit_reg_op,
    input wire logic mask_destination_select_bit,
    input wire logic [7:0] exit_offset_field,
    // console and adder controls
    input wire logic console_mask_select,
    input wire logic q_to_adder_flag,
    input wire logic [15:0] adder_out,
    // interrupt lines from fault logic and I/O
    input wire logic [15:0] interrupt_lines,
    // storage answer for the exit read
    input wire logic return_word_valid,
    input wire logic [15:0] return_word,
    // mask back to the datapath
    output logic [15:0] mask_to_adder,
    // interrupt state and vector
    output logic interrupt_pending,
    output logic interrupt_taken_flag,
    output logic interrupt_active,
    output logic [3:0] state_code,
    output logic [7:0] exit_offset,
    output logic [15:0] return_addr,
    output logic [15:0] handler_addr,
    // Y register transfer
    output logic y_load,
    output logic [3:0] y_code,
    // exit instruction read and jump
    output logic exit_read_req,
    output logic [15:0] exit_read_addr,
    output logic exit_jump,
    output logic [15:0] exit_jump_addr
);
    logic mask_load_flag;
    logic enable_first;
    logic enable_second;
    logic [15:0] mask;
    logic [15:0] hold;
    logic capture;
    logic mask_load;
    logic entry_clear;
    logic exit_clear;
    logic flags_clear;
    logic take;
    logic next_y_load;
    logic exit_wait;

    // lowest set bit wins
    function automatic logic [3:0] lowest_line(input logic [15:0] bits);
        logic [3:0] code;
        code = 4'h0;
        for (int i = 15; i >= 0; i--)
        begin
            if (bits[i])
                code = i[3:0];
        end
        return code;
    endfunction : lowest_line

    // sequencer decodes
    assign capture = cycle_a && time_050 && enable_second && !interrupt_taken_flag;
    assign mask_load = mask_load_flag && time_300;
    assign entry_clear = cycle_a && time_300 && interrupt_taken_flag
        && (ind_addr_phase || read_next_instruction_phase);
    assign exit_clear = cycle_a && time_200 && reg_phase && interrupt_exit_reg_op;
    assign flags_clear = entry_clear || exit_clear;
    assign interrupt_pending = |hold;
    assign take = cycle_a && time_250 && enable_second && interrupt_pending
        && (ind_addr_phase || read_next_instruction_phase);

    // four slices make up the sixteen-line mask and holding registers
    genvar s;
    generate
        for (s = 0; s < intr_mask_pkg::SLICE_COUNT; s++)
        begin : g_slice
            mask_interrupt_slice u_slice (
                .core_clk(core_clk),
                .arst_n(arst_n),
                .mask_load(mask_load),
                .mask_data(adder_out[s*4 +: 4]),
                .capture(capture),
                .hold_clear(flags_clear),
                .lines(interrupt_lines[s*4 +: 4]),
                .mask(mask[s*4 +: 4]),
                .hold(hold[s*4 +: 4])
            );
        end
    endgenerate

    assign mask_to_adder = mask;
    assign interrupt_active = enable_second;

    // adder to mask control flag; cleared once the load is done
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            mask_load_flag <= 1'b0;
        else if ((cycle_a && time_250 && reg_phase && inter_register_instr && mask_destination_select_bit)
                 || (console_mask_select && q_to_adder_flag))
            mask_load_flag <= 1'b1;
        else if (time_300)
            mask_load_flag <= 1'b0;
    end

    // first enable flag
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            enable_first <= 1'b0;
        else if (cycle_b && time_250 && reg_phase && (exit_interrupt_instr || enable_interrupt_instr))
            enable_first <= 1'b1;
        else if (flags_clear)
            enable_first <= 1'b0;
    end

    // second enable flag; exit instruction gets no delay
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            enable_second <= 1'b0;
        else if ((cycle_b && time_200 && ind_addr_phase && enable_first)
                 || (cycle_b && time_250 && reg_phase && exit_interrupt_instr))
            enable_second <= 1'b1;
        else if (flags_clear)
            enable_second <= 1'b0;
    end

    // interrupt-taken flag
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            interrupt_taken_flag <= 1'b0;
        else if (take)
            interrupt_taken_flag <= 1'b1;
        else if (flags_clear)
            interrupt_taken_flag <= 1'b0;
    end

    // state code and vector latched when the interrupt is taken
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_code <= intr_mask_pkg::CODE_RESET;
            exit_offset <= 8'h00;
            return_addr <= intr_mask_pkg::RETURN_BASE;
            handler_addr <= intr_mask_pkg::HANDLER_BASE;
        end
        else if (take)
        begin
            state_code <= lowest_line(hold);
            exit_offset <= {2'b00, lowest_line(hold), 2'b00};
            return_addr <= intr_mask_pkg::RETURN_BASE + {6'h00, lowest_line(hold), 2'b00};
            handler_addr <= intr_mask_pkg::HANDLER_BASE + {6'h00, lowest_line(hold), 2'b00};
        end
    end

    // transfer of the code to the Y register
    assign next_y_load = take;
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            y_load <= 1'b0;
            y_code <= intr_mask_pkg::CODE_RESET;
        end
        else
        begin
            y_load <= next_y_load;
            if (next_y_load)
                y_code <= lowest_line(hold);
        end
    end

    // exit instruction: read return word by offset, then jump to it
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            exit_read_req <= 1'b0;
            exit_read_addr <= intr_mask_pkg::RETURN_BASE;
            exit_wait <= 1'b0;
            exit_jump <= 1'b0;
            exit_jump_addr <= 16'h0000;
        end
        else
        begin
            exit_read_req <= 1'b0;
            exit_jump <= 1'b0;
            if (cycle_a && time_200 && reg_phase && exit_interrupt_instr && !exit_wait)
            begin
                exit_read_req <= 1'b1;
                exit_read_addr <= intr_mask_pkg::RETURN_BASE + {8'h00, exit_offset_field};
                exit_wait <= 1'b1;
            end
            else if (exit_wait && return_word_valid)
            begin
                exit_jump <= 1'b1;
                exit_jump_addr <= return_word;
                exit_wait <= 1'b0;
            end
        end
    end

    // checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);

    property p_masked_not_held;
        $rose(hold[0]) |-> $past(mask[0]) && $past(interrupt_lines[0]);
    endproperty
    a_masked_not_held: assert property (p_masked_not_held) else $error("held bit without mask and line");

    property p_capture_timing;
        $rose(hold[5]) |-> $past(cycle_a && time_050 && enable_second && !interrupt_taken_flag);
    endproperty
    a_capture_timing: assert property (p_capture_timing) else $error("holding bit set outside A-cycle 50");

    property p_mask_load;
        mask_load_flag && time_300 |=> mask == $past(adder_out);
    endproperty
    a_mask_load: assert property (p_mask_load) else $error("mask did not load at 300");

    property p_mask_flag_ir;
        cycle_a && time_250 && reg_phase && inter_register_instr && mask_destination_select_bit |=> mask_load_flag;
    endproperty
    a_mask_flag_ir: assert property (p_mask_flag_ir) else $error("mask-load flag not set");

    property p_mask_flag_console;
        console_mask_select && q_to_adder_flag |=> mask_load_flag;
    endproperty
    a_mask_flag_console: assert property (p_mask_flag_console) else $error("console mask load not flagged");

    property p_lowest_wins;
        take && hold[3] && hold[12] && !(|hold[2:0]) |=> state_code == 4'h3 && exit_offset == 8'h0C;
    endproperty
    a_lowest_wins: assert property (p_lowest_wins) else $error("priority not lowest line");

    property p_vector;
        $rose(interrupt_taken_flag) |-> return_addr == 16'h0100 + {6'h00, state_code, 2'b00}
            && handler_addr == return_addr + 16'h0001;
    endproperty
    a_vector: assert property (p_vector) else $error("vector addresses wrong");

    property p_no_pending_no_take;
        !interrupt_pending |=> !$rose(interrupt_taken_flag);
    endproperty
    a_no_pending_no_take: assert property (p_no_pending_no_take) else $error("taken without pending");

    property p_entry_clears;
        entry_clear && !take |=> !enable_first && !enable_second && !interrupt_taken_flag && hold == 16'h0000;
    endproperty
    a_entry_clears: assert property (p_entry_clears) else $error("flags not cleared on entry");

    property p_y_transfer;
        take |=> y_load && y_code == state_code ##1 !y_load;
    endproperty
    a_y_transfer: assert property (p_y_transfer) else $error("code not passed to Y");

    property p_enable_delay;
        $rose(enable_first) && !$past(exit_interrupt_instr) |-> !enable_second;
    endproperty
    a_enable_delay: assert property (p_enable_delay) else $error("second enable not delayed");

    c_take: cover property (take);
    c_mask_load: cover property (mask_load);
    c_exit_jump: cover property (exit_read_req ##[1:20] exit_jump);
    c_exit_clear: cover property (exit_clear && interrupt_active);
endmodule : interrupt_mask_priority
`default_nettype wire

// [rtl/intr_mask_pkg.sv]
// constants shared by the interrupt mask and priority front end
`default_nettype none
package intr_mask_pkg;
    localparam int LINE_COUNT = 16;
    localparam int SLICE_WIDTH = 4;
    localparam int SLICE_COUNT = LINE_COUNT / SLICE_WIDTH;
    localparam int CODE_WIDTH = 4;
    localparam int ADDR_WIDTH = 16;
    localparam int OFFSET_WIDTH = 8;
    // reset values
    localparam logic [15:0] MASK_RESET = 16'h0000;
    localparam logic [15:0] HOLD_RESET = 16'h0000;
    localparam logic [3:0] CODE_RESET = 4'h0;
    // exit offset is state number times this step
    localparam logic [7:0] OFFSET_STEP = 8'h04;
    localparam int OFFSET_SHIFT = 2;
    // return-address table and first handler word
    localparam logic [15:0] RETURN_BASE = 16'h0100;
    localparam logic [15:0] HANDLER_BASE = 16'h0101;
endpackage : intr_mask_pkg
`default_nettype wire

// [rtl/mask_interrupt_slice.sv]
// one 4-bit slice of the mask register and interrupt holding register
`default_nettype none
module mask_interrupt_slice (
    // clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    // mask load from the adder/shifter
    input wire logic mask_load,
    input wire logic [3:0] mask_data,
    // holding register capture and clear
    input wire logic capture,
    input wire logic hold_clear,
    input wire logic [3:0] lines,
    // stored state
    output logic [3:0] mask,
    output logic [3:0] hold
);
    // mask bit n enables line n of this slice
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            mask <= intr_mask_pkg::MASK_RESET[3:0];
        else if (mask_load)
            mask <= mask_data;
    end

    // a line is held only where its mask bit is set; capture with clear keeps only the newly captured lines
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            hold <= intr_mask_pkg::HOLD_RESET[3:0];
        else if (capture)
            hold <= (hold_clear ? 4'h0 : hold) | (mask & lines);
        else if (hold_clear)
            hold <= 4'h0;
    end
endmodule : mask_interrupt_slice
`default_nettype wire

// [tb/interrupt_source_model.sv]
// line source model: internal faults and i/o requests onto the interrupt line bus
`default_nettype none
module interrupt_source_model (
    // internal fault sources
    input wire logic parity_err,
    input wire logic protect_fault,
    input wire logic power_fail,
    // external requests
    input wire logic lowspeed_io,
    input wire logic [13:0] ext_req,
    // line bus toward the front end
    output logic [15:0] lines
);
    timeunit 1ns;
    timeprecision 1ps;
    // line 0 merges the faults, line 1 carries the slow i/o request
    assign lines = {ext_req, lowspeed_io, parity_err | protect_fault | power_fail};
endmodule : interrupt_source_model
`default_nettype wire

// [tb/testbench.sv]
// self-checking bench for the interrupt mask and priority front end
`default_nettype none
`define CHK(nm, e, g) check(nm, 16'(e), 16'(g));
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    // strobe sets {cycle_a, cycle_b, t050, t200, t250, t300}
    localparam logic [5:0] A50 = 6'h28, A200 = 6'h24, A250 = 6'h22, A300 = 6'h21, B200 = 6'h14, B250 = 6'h12;
    logic core_clk, arst_n, cycle_a, cycle_b, time_050, time_200, time_250, time_300;
    logic reg_phase, ind_addr_phase, read_next_instruction_phase;
    logic inter_register_instr, exit_interrupt_instr, enable_interrupt_instr, interrupt_exit_reg_op;
    logic mask_destination_select_bit, console_mask_select, q_to_adder_flag, return_word_valid;
    logic [7:0] exit_offset_field, exit_offset;
    logic [15:0] adder_out, interrupt_lines, return_word, mask_to_adder, return_addr, handler_addr;
    logic [15:0] exit_read_addr, exit_jump_addr;
    logic interrupt_pending, interrupt_taken_flag, interrupt_active, y_load, exit_read_req, exit_jump;
    logic [3:0] state_code, y_code;
    logic parity_err, protect_fault, power_fail, lowspeed_io;
    logic [13:0] ext_req;
    int err_count = 0;
    int checked = 0;
    int cycles = 0;
    // design and line source
    interrupt_mask_priority i_interrupt_mask_priority (
        .core_clk, .arst_n, .cycle_a, .cycle_b, .time_050, .time_200, .time_250, .time_300,
        .reg_phase, .ind_addr_phase, .read_next_instruction_phase, .inter_register_instr,
        .exit_interrupt_instr, .enable_interrupt_instr, .interrupt_exit_reg_op, .mask_destination_select_bit,
        .exit_offset_field, .console_mask_select, .q_to_adder_flag, .adder_out, .interrupt_lines,
        .return_word_valid, .return_word, .mask_to_adder, .interrupt_pending, .interrupt_taken_flag,
        .interrupt_active, .state_code, .exit_offset, .return_addr, .handler_addr, .y_load, .y_code,
        .exit_read_req, .exit_read_addr, .exit_jump, .exit_jump_addr
    );
    interrupt_source_model i_interrupt_source_model (
        .parity_err, .protect_fault, .power_fail, .lowspeed_io, .ext_req, .lines(interrupt_lines)
    );
    // compare and count
    task automatic check(input string nm, input logic [15:0] e, input logic [15:0] g);
        checked++;
        if (g !== e)
        begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : check
    // one strobe cycle with phases held, then settle past the sampling edge
    task automatic cyc(input logic [5:0] s, input logic [2:0] ph);
        @(posedge core_clk);
        {cycle_a, cycle_b, time_050, time_200, time_250, time_300} <= s;
        {reg_phase, ind_addr_phase, read_next_instruction_phase} <= ph;
        @(posedge core_clk);
        {cycle_a, cycle_b, time_050, time_200, time_250, time_300} <= 6'h00;
        #1;
    endtask : cyc
    // mask load by console or inter-register path, then a refused time 300
    task automatic load_mask(input logic [15:0] v, input logic con);
        @(posedge core_clk);
        adder_out <= v;
        if (con)
            {console_mask_select, q_to_adder_flag} <= 2'b11;
        else
            {inter_register_instr, mask_destination_select_bit} <= 2'b11;
        cyc(con ? 6'h00 : A250, 3'b100);
        @(posedge core_clk);
        {console_mask_select, q_to_adder_flag, inter_register_instr, mask_destination_select_bit} <= 4'h0;
        cyc(A300, 3'b100);
        @(posedge core_clk);
        #1;
        `CHK("mask", v, mask_to_adder)
        @(posedge core_clk);
        adder_out <= ~v;
        cyc(A300, 3'b100);
        `CHK("mask kept", v, mask_to_adder)
    endtask : load_mask
    // enable, capture and take with a given mask and line set
    task automatic take_case(input logic [15:0] m, input logic [15:0] l, input logic con);
        logic hit;
        logic [3:0] code;
        logic [7:0] off;
        hit = |(m & l);
        code = 4'h0;
        for (int i = 15; i >= 0; i--)
            if (m[i] & l[i])
                code = i[3:0];
        off = {2'b00, code, 2'b00};
        load_mask(m, con);
        @(posedge core_clk);
        {ext_req, lowspeed_io} <= l[15:1];
        parity_err <= l[0] & con; // fault sources take turns on line 0
        {protect_fault, power_fail} <= {2{l[0] & ~con}};
        enable_interrupt_instr <= 1'b1;
        cyc(B250, 3'b100);
        @(posedge core_clk);
        enable_interrupt_instr <= 1'b0;
        cyc(B200, 3'b010);
        `CHK("active", 1'b1, interrupt_active)
        cyc(A50, 3'b010);
        `CHK("pending", hit, interrupt_pending)
        cyc(A250, 3'b010);
        `CHK("taken", hit, interrupt_taken_flag)
        `CHK("y_load", hit, y_load)
        if (hit)
        begin
            `CHK("state_code", code, state_code)
            `CHK("y_code", code, y_code)
            `CHK("exit_offset", off, exit_offset)
            `CHK("return_addr", 16'h0100 + off, return_addr)
            `CHK("handler_addr", 16'h0101 + off, handler_addr)
            cyc(A300, 3'b010);
        end
        else
        begin
            @(posedge core_clk);
            interrupt_exit_reg_op <= 1'b1;
            cyc(A200, 3'b100);
            interrupt_exit_reg_op <= 1'b0;
        end
        `CHK("flags clear", 2'b00, {interrupt_active, interrupt_taken_flag})
        `CHK("hold clear", 1'b0, interrupt_pending)
        @(posedge core_clk);
        {parity_err, protect_fault, power_fail, lowspeed_io, ext_req} <= 18'h00000;
    endtask : take_case
    // exit instruction reads the return word and jumps to it
    task automatic exit_read();
        @(posedge core_clk);
        exit_interrupt_instr <= 1'b1;
        exit_offset_field <= 8'h2C;
        cyc(A200, 3'b100);
        `CHK("exit_read_req", 1'b1, exit_read_req)
        `CHK("exit_read_addr", 16'h012C, exit_read_addr)
        exit_interrupt_instr <= 1'b0;
        return_word_valid <= 1'b1;
        return_word <= 16'h5A3C;
        @(posedge core_clk);
        #1;
        `CHK("exit_jump", 1'b1, exit_jump)
        `CHK("exit_jump_addr", 16'h5A3C, exit_jump_addr)
        return_word_valid <= 1'b0;
        return_word <= 16'hA5C3;
        @(posedge core_clk);
        #1;
        `CHK("exit_jump end", 1'b0, exit_jump)
        `CHK("exit_jump kept", 16'h5A3C, exit_jump_addr)
        // exit instruction enables at once, then the exit op clears
        @(posedge core_clk);
        exit_interrupt_instr <= 1'b1;
        cyc(B250, 3'b100);
        `CHK("exit enable", 1'b1, interrupt_active)
        exit_interrupt_instr <= 1'b0;
        interrupt_exit_reg_op <= 1'b1;
        cyc(A200, 3'b100);
        interrupt_exit_reg_op <= 1'b0;
        `CHK("exit clear", 1'b0, interrupt_active)
    endtask : exit_read
    // counts and verdict
    task automatic print_verdict();
        $display("checks %0d errors %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : print_verdict
    // clock
    initial
    begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    // hang guard
    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            err_count++;
            print_verdict();
        end
    end
    // main sequence
    initial
    begin
        {arst_n, cycle_a, cycle_b, time_050, time_200, time_250, time_300} = 7'h00;
        {reg_phase, ind_addr_phase, read_next_instruction_phase, inter_register_instr} = 4'h0;
        {exit_interrupt_instr, enable_interrupt_instr, interrupt_exit_reg_op} = 3'h0;
        {mask_destination_select_bit, console_mask_select, q_to_adder_flag, return_word_valid} = 4'h0;
        {parity_err, protect_fault, power_fail, lowspeed_io, ext_req} = 18'h00000;
        exit_offset_field = 8'h00;
        adder_out = 16'h0000;
        return_word = 16'h0000;
        repeat (8) @(posedge core_clk);
        arst_n <= 1'b1;
        @(posedge core_clk);
        #1;
        `CHK("mask reset", 16'h0000, mask_to_adder)
        `CHK("return reset", 16'h0100, return_addr)
        `CHK("pending reset", 1'b0, interrupt_pending)
        take_case(16'hFFFF, 16'h1020, 1'b1);
        take_case(16'hFFFF, 16'h1008, 1'b0);
        take_case(16'hFFDF, 16'h1020, 1'b0);
        take_case(16'h8000, 16'h8000, 1'b1);
        take_case(16'h0003, 16'h0003, 1'b0);
        take_case(16'h0F00, 16'h00FF, 1'b1);
        exit_read();
        print_verdict();
    end
endmodule : testbench
`default_nettype wire
